// file: rtl/reset_timeout_sequencer.sv
`timescale 1ns/1ns
module reset_timeout_sequencer
  import reset_seq_pkg::*;
#(
  parameter int unsigned PWRUP_CYC  = PWRUP_DELAY_CYC,
  parameter int unsigned PLL_CYC    = PLL_SETTLE_CYC,
  parameter int unsigned OSC_CYC    = OSC_STARTUP_CYC,
  parameter int unsigned BROWN_CYC  = BROWNOUT_MIN_CYC,
  parameter int unsigned FILTER_CYC = PIN_FILTER_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        supply_rise_i,
  input  wire logic        supply_low_i,
  input  wire logic        master_clear_pin_n_i,
  input  wire logic        watchdog_timeout_i,
  input  wire logic        halted_i,
  input  wire logic        wake_irq_i,
  input  wire logic        osc_input_pin_i,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hsel,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             master_clear_pin_o,
  output logic             master_clear_pin_oe_o,
  output logic             core_reset_o,
  output logic             regs_reset_o,
  output logic             keep_regs_undef_o,
  output logic             wake_o,
  output logic [2:0]       reset_cause_o
);
  import reset_seq_pkg::*;

  // ==========================================================================
  // Pin drive: never driven, watchdog included
  assign master_clear_pin_o    = 1'b0;
  assign master_clear_pin_oe_o = 1'b0;

  // ==========================================================================
  // Reset pin noise filter
  logic [CNT_W-1:0] filt_cnt;
  logic             pin_low;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      filt_cnt <= '0;
      pin_low  <= 1'b0;
    end else if (master_clear_pin_n_i == !pin_low) begin
      filt_cnt <= '0;
    end else if (filt_cnt >= CNT_W'(FILTER_CYC - 1)) begin
      filt_cnt <= '0;
      pin_low  <= !master_clear_pin_n_i;
    end else begin
      filt_cnt <= filt_cnt + 1'b1;
    end
  end

  // ==========================================================================
  // Brown-out qualification, always on
  logic [CNT_W-1:0] brown_cnt;
  logic             brown_active;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      brown_cnt    <= '0;
      brown_active <= 1'b0;
    end else if (!supply_low_i) begin
      brown_cnt    <= '0;
      brown_active <= 1'b0;
    end else if (brown_cnt >= CNT_W'(BROWN_CYC - 1)) begin
      brown_active <= 1'b1;
    end else begin
      brown_cnt <= brown_cnt + 1'b1;
    end
  end

  // ==========================================================================
  // Internal RC tick and oscillator edge detect
  logic [1:0] rc_div;
  logic       rc_tick;
  logic       osc_q;
  logic       osc_edge;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rc_div <= '0;
    end else begin
      rc_div <= rc_div + 1'b1;
    end
  end
  assign rc_tick = (rc_div == 2'(RC_DIV - 1));

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= osc_input_pin_i;
    end
  end
  assign osc_edge = osc_input_pin_i && !osc_q;

  // ==========================================================================
  // Configuration and status registers
  osc_mode_t osc_mode;
  logic      pwrup_en_n;
  logic      timeout_flag;
  logic      powerdown_flag;
  logic      por_status;
  logic      brown_status;

  // ==========================================================================
  // Cause sorting
  logic   por_evt;
  logic   dog_evt;
  logic   wake_dog;
  logic   wake_int;
  logic   pin_q;
  logic   brown_q;
  logic   pin_evt;
  logic   brown_evt;
  cause_t cause;
  assign por_evt   = supply_rise_i;
  assign pin_evt   = pin_low && !pin_q;
  assign brown_evt = brown_active && !brown_q;
  assign dog_evt   = watchdog_timeout_i && !halted_i;
  assign wake_dog  = watchdog_timeout_i && halted_i;
  assign wake_int  = wake_irq_i && halted_i && !pin_low;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_q   <= 1'b0;
      brown_q <= 1'b0;
    end else begin
      pin_q   <= pin_low;
      brown_q <= brown_active;
    end
  end

  always_comb begin
    cause = CAUSE_NONE;
    if (por_evt) begin
      cause = CAUSE_POWER_ON;
    end else if (brown_evt) begin
      cause = CAUSE_BROWNOUT;
    end else if (pin_evt && halted_i) begin
      cause = CAUSE_PIN_HALT;
    end else if (pin_evt) begin
      cause = CAUSE_PIN_RUN;
    end else if (dog_evt) begin
      cause = CAUSE_WATCHDOG;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      reset_cause_o <= CAUSE_NONE;
    end else if (cause != CAUSE_NONE) begin
      reset_cause_o <= cause;
    end
  end

  // ==========================================================================
  // Time-out sequencer
  seq_state_t       state;
  logic [CNT_W-1:0] cnt;
  logic             use_pll;
  logic             use_osc;
  logic             do_delay;
  logic             full_seq;
  assign use_pll = (osc_mode == crystal_pll_mode) ||
                   (osc_mode == ext_clock_pll_mode);
  assign use_osc = (osc_mode == crystal_mode) ||
                   (osc_mode == crystal_pll_mode);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state    <= ST_HOLD;
      cnt      <= '0;
      do_delay <= 1'b1;
      full_seq <= 1'b1;
    end else if (por_evt || brown_active) begin
      state    <= ST_HOLD;
      cnt      <= '0;
      do_delay <= !pwrup_en_n;
      full_seq <= 1'b1;
    end else if (cause != CAUSE_NONE) begin
      state    <= ST_HOLD;
      cnt      <= '0;
      do_delay <= 1'b0;
      full_seq <= 1'b0;
    end else if (wake_dog || wake_int) begin
      state    <= ST_HOLD;
      cnt      <= '0;
      do_delay <= 1'b0;
      full_seq <= 1'b1;
    end else begin
      case (state)
        ST_HOLD: begin
          cnt <= '0;
          if (do_delay) begin
            state <= ST_PWRUP;
          end else begin
            state <= ST_PLL;
          end
        end
        ST_PWRUP: begin
          if (cnt >= CNT_W'(PWRUP_CYC / RC_DIV)) begin
            cnt   <= '0;
            state <= ST_PLL;
          end else if (rc_tick) begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_PLL: begin
          if (!use_pll || !full_seq || cnt >= CNT_W'(PLL_CYC)) begin
            cnt   <= '0;
            state <= ST_OSC;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_OSC: begin
          if (!use_osc || !full_seq || cnt >= CNT_W'(OSC_CYC)) begin
            cnt   <= '0;
            state <= ST_WAIT;
          end else if (osc_edge) begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_WAIT: begin
          if (!pin_low) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_HOLD;
        end
      endcase
    end
  end

  assign core_reset_o = (state != ST_RUN) || pin_low || brown_active;
  assign regs_reset_o = (cause != CAUSE_NONE) || brown_active;
  assign wake_o       = (wake_dog || wake_int) && state == ST_RUN;

  // Unaffected class is only undefined after power-on
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      keep_regs_undef_o <= 1'b1;
    end else if (por_evt) begin
      keep_regs_undef_o <= 1'b1;
    end else if (state == ST_RUN) begin
      keep_regs_undef_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Timeout and powerdown flags
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end else begin
      case (cause)
        CAUSE_POWER_ON, CAUSE_BROWNOUT: begin
          timeout_flag   <= 1'b1;
          powerdown_flag <= 1'b1;
        end
        CAUSE_WATCHDOG: begin
          timeout_flag   <= 1'b0;
          powerdown_flag <= 1'b1;
        end
        CAUSE_PIN_HALT: begin
          timeout_flag   <= 1'b1;
          powerdown_flag <= 1'b0;
        end
        default: begin
          if (wake_dog) begin
            timeout_flag   <= 1'b0;
            powerdown_flag <= 1'b0;
          end else if (wake_int) begin
            timeout_flag   <= 1'b1;
            powerdown_flag <= 1'b0;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // AHB-Lite slave
  logic        ap_valid;
  logic        ap_write;
  logic [31:0] ap_addr;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= '0;
    end else if (hready) begin
      ap_valid <= hsel && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
      ap_write <= hwrite;
      ap_addr  <= haddr;
    end
  end

  logic wr_pcs;
  logic wr_cfg;
  assign wr_pcs = ap_valid && ap_write && ap_addr == PCS_ADDR;
  assign wr_cfg = ap_valid && ap_write && ap_addr == CONFIG_ADDR;

  // Status bits: hardware clear wins over software set
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      por_status   <= 1'b0;
      brown_status <= 1'b0;
    end else begin
      if (por_evt) begin
        por_status <= 1'b0;
      end else if (wr_pcs) begin
        por_status <= hwdata[PCS_POWER_ON_BIT];
      end
      if (brown_evt) begin
        brown_status <= 1'b0;
      end else if (wr_pcs) begin
        brown_status <= hwdata[PCS_BROWNOUT_BIT];
      end
    end
  end

  // Configuration survives all resets but the bus reset
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      osc_mode   <= crystal_mode;
      pwrup_en_n <= 1'b0;
    end else if (wr_cfg) begin
      osc_mode   <= osc_mode_t'(hwdata[CFG_MODE_LSB +: 2]);
      pwrup_en_n <= hwdata[CFG_DELAY_EN_N_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      hrdata <= '0;
    end else if (hready) begin
      hrdata <= '0;
      if (hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
        case (haddr)
          PCS_ADDR: begin
            hrdata[PCS_POWER_ON_BIT] <= por_status;
            hrdata[PCS_BROWNOUT_BIT] <= brown_status;
          end
          FLAGS_ADDR: begin
            hrdata[FLG_TIMEOUT_BIT]   <= timeout_flag;
            hrdata[FLG_POWERDOWN_BIT] <= powerdown_flag;
          end
          CONFIG_ADDR: begin
            hrdata[CFG_MODE_LSB +: 2]  <= osc_mode;
            hrdata[CFG_DELAY_EN_N_BIT] <= pwrup_en_n;
          end
          default: begin
            hrdata <= '0;
          end
        endcase
      end
    end
  end

endmodule

// file: rtl/reset_seq_pkg.sv
package reset_seq_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned PWRUP_DELAY_MS = 72;
  localparam int unsigned PWRUP_DELAY_CYC = PWRUP_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned PLL_SETTLE_US = 2000;
  localparam int unsigned PLL_SETTLE_CYC = PLL_SETTLE_US * (CLK_HZ / 1000000);
  localparam int unsigned OSC_STARTUP_CYC = 1024;
  localparam int unsigned BROWNOUT_MIN_US = 100;
  localparam int unsigned BROWNOUT_MIN_CYC =
    BROWNOUT_MIN_US * (CLK_HZ / 1000000);
  localparam int unsigned PIN_FILTER_CYC = 8;
  localparam int unsigned RC_DIV = 4;
  localparam int unsigned CNT_W = 32;

  // ==========================================================================
  // Oscillator modes
  typedef enum logic [1:0] {
    crystal_mode        = 2'h0,
    ext_clock_mode      = 2'h1,
    crystal_pll_mode    = 2'h2,
    ext_clock_pll_mode  = 2'h3
  } osc_mode_t;

  // ==========================================================================
  // Sequencer states (Gray along the usual path except ST_OSC to ST_WAIT)
  typedef enum logic [2:0] {
    ST_HOLD   = 3'h0,
    ST_PWRUP  = 3'h1,
    ST_PLL    = 3'h3,
    ST_OSC    = 3'h2,
    ST_RUN    = 3'h6,
    ST_WAIT   = 3'h7
  } seq_state_t;

  // ==========================================================================
  // Reset causes
  typedef enum logic [2:0] {
    CAUSE_NONE      = 3'h0,
    CAUSE_POWER_ON  = 3'h1,
    CAUSE_PIN_RUN   = 3'h2,
    CAUSE_PIN_HALT  = 3'h3,
    CAUSE_WATCHDOG  = 3'h4,
    CAUSE_BROWNOUT  = 3'h5
  } cause_t;

  // ==========================================================================
  // Register map
  localparam logic [31:0] PCS_ADDR     = 32'h0000_0000;
  localparam logic [31:0] FLAGS_ADDR   = 32'h0000_0004;
  localparam logic [31:0] CONFIG_ADDR  = 32'h0000_0008;
  localparam int unsigned PCS_BROWNOUT_BIT = 0;
  localparam int unsigned PCS_POWER_ON_BIT = 1;
  localparam int unsigned FLG_POWERDOWN_BIT = 0;
  localparam int unsigned FLG_TIMEOUT_BIT = 1;
  localparam int unsigned CFG_MODE_LSB = 0;
  localparam int unsigned CFG_DELAY_EN_N_BIT = 3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// file: tb/reset_seq_asserts.sv
`timescale 1ns/1ns
module reset_seq_asserts
  import reset_seq_pkg::*;
#(
  parameter int unsigned BROWN_CYC  = 4,
  parameter int unsigned FILTER_CYC = 4
) (
  input wire logic       ref_clk_i,
  input wire logic       reset_i,
  input wire logic       supply_rise_i,
  input wire logic       supply_low_i,
  input wire logic       master_clear_pin_n_i,
  input wire logic       watchdog_timeout_i,
  input wire logic       halted_i,
  input wire logic       wake_irq_i,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       master_clear_pin_oe_o,
  input wire logic       core_reset_o,
  input wire logic       regs_reset_o,
  input wire logic       keep_regs_undef_o,
  input wire logic       wake_o,
  input wire logic [2:0] reset_cause_o
);
  // ======
  // Shared sequences
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_pin_low;
    (!master_clear_pin_n_i && FILTER_CYC < 8) [*8];
  endsequence
  sequence s_supply_low;
    (supply_low_i && BROWN_CYC < 8) [*8];
  endsequence
  sequence s_wake_req;
    (watchdog_timeout_i || wake_irq_i) && halted_i && !core_reset_o;
  endsequence
  // ======
  // Checks
  AST_NO_PIN_DRIVE: assert property (!master_clear_pin_oe_o)
    else $error("reset pin driven");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus slave not ready");
  AST_CORE_HELD: assert property (
    regs_reset_o |-> ##[0:2] core_reset_o)
    else $error("reset cause without core reset");
  AST_PIN_HOLD: assert property (s_pin_low |=> core_reset_o)
    else $error("long pin low without core reset");
  AST_BROWN_HOLD: assert property (s_supply_low |=> core_reset_o)
    else $error("long brown-out without core reset");
  AST_POR_CAUSE: assert property (
    supply_rise_i |-> ##[1:4]
    (reset_cause_o == CAUSE_POWER_ON && keep_regs_undef_o))
    else $error("power-on not recorded");
  AST_WATCHDOG_CAUSE: assert property (
    watchdog_timeout_i && !halted_i && !core_reset_o |-> ##[1:4]
    reset_cause_o == CAUSE_WATCHDOG)
    else $error("watchdog reset not recorded");
  AST_WAKE_PULSE: assert property (s_wake_req |-> ##[0:3] wake_o)
    else $error("wake not signalled");
endmodule
bind reset_timeout_sequencer reset_seq_asserts #(
  .BROWN_CYC  (BROWN_CYC),
  .FILTER_CYC (FILTER_CYC)
) reset_seq_asserts_inst (
  .ref_clk_i, .reset_i, .supply_rise_i, .supply_low_i,
  .master_clear_pin_n_i, .watchdog_timeout_i, .halted_i, .wake_irq_i,
  .hreadyout, .hresp, .master_clear_pin_oe_o, .core_reset_o,
  .regs_reset_o, .keep_regs_undef_o, .wake_o, .reset_cause_o
);

// file: tb/far_side_model.sv
`timescale 1ns/1ns
module far_side_model (
  input  wire logic ref_clk_i,
  input  wire logic pull_low_i,
  input  wire logic pin_o_i,
  input  wire logic pin_oe_i,
  output logic      pin_n_o,
  output logic      osc_o
);
  logic [1:0] div = 2'h0;
  // ======
  // Reset pin with pull-up, low while any party pulls
  assign pin_n_o = !(pull_low_i || (pin_oe_i && !pin_o_i));
  // ======
  // Crystal source, four clocks a period
  always_ff @(posedge ref_clk_i) begin
    div <= div + 2'h1;
  end
  assign osc_o = div[1];
endmodule

// file: tb/test_reset_timeout_sequencer.sv
`timescale 1ns/1ns
module test_reset_timeout_sequencer;
  import reset_seq_pkg::*;
  // ======
  // Shortened counts and bench state
  localparam int PW = 40;
  localparam int PL = 10;
  localparam int OC = 16;
  localparam int SPAN = 60;
  logic        ref_clk_i;
  logic        reset_i = 1'b1;
  logic        halted_i = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [4:0]  ev = 5'h00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [2:0]  reset_cause_o;
  logic        supply_rise_i, supply_low_i, master_clear_pin_n_i;
  logic        watchdog_timeout_i, wake_irq_i, osc_input_pin_i, hresp;
  logic        hreadyout, master_clear_pin_o, master_clear_pin_oe_o;
  logic        core_reset_o, regs_reset_o, keep_regs_undef_o, wake_o;
  int          n_mismatch = 0;
  int          compares = 0;
  int          n_wake = 0;
  int          n_rst = 0;
  int          n_cyc;
  assign supply_low_i = ev[0];
  assign watchdog_timeout_i = ev[2];
  assign wake_irq_i = ev[3];
  assign supply_rise_i = ev[4];

  reset_timeout_sequencer #(
    .PWRUP_CYC  (PW),
    .PLL_CYC    (PL),
    .OSC_CYC    (OC),
    .BROWN_CYC  (4),
    .FILTER_CYC (4)
  ) reset_timeout_sequencer_inst (
    .ref_clk_i, .reset_i, .supply_rise_i, .supply_low_i,
    .master_clear_pin_n_i, .watchdog_timeout_i, .halted_i, .wake_irq_i,
    .osc_input_pin_i, .haddr, .htrans, .hwrite, .hsize(HSIZE_WORD),
    .hwdata, .hsel(1'b1), .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .master_clear_pin_o, .master_clear_pin_oe_o, .core_reset_o,
    .regs_reset_o, .keep_regs_undef_o, .wake_o, .reset_cause_o
  );
  far_side_model far_side_model_inst (
    .ref_clk_i,
    .pull_low_i (ev[1]),
    .pin_o_i    (master_clear_pin_o),
    .pin_oe_i   (master_clear_pin_oe_o),
    .pin_n_o    (master_clear_pin_n_i),
    .osc_o      (osc_input_pin_i)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (wake_o === 1'b1) n_wake++;
    if (regs_reset_o === 1'b1) n_rst++;
  end
  // ======
  // Shared tasks
  task automatic tally_and_finish();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input int lo, input int hi);
    compares++;
    if (n_cyc < lo || n_cyc > hi) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %0d cycles", $time, n_cyc);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (hreadyout !== 1'b1 && k < 16);
    if (hreadyout !== 1'b1) k = 32;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (hreadyout !== 1'b1 && k < 32);
    q = hrdata;
    if (k >= 32) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wait_core(input logic v);
    n_cyc = 0;
    while (core_reset_o !== v && n_cyc < 3000) begin
      @(posedge ref_clk_i);
      n_cyc++;
    end
    if (n_cyc >= 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  task automatic settle();
    repeat (6) @(posedge ref_clk_i);
    wait_core(1'b0);
  endtask
  // Event lines: 0 supply low, 1 pin low, 2 watchdog, 3 irq, 4 rise
  task automatic drive(input int s, input int c);
    ev <= 5'h01 << s;
    repeat (c) @(posedge ref_clk_i);
    ev <= 5'h00;
    @(posedge ref_clk_i);
  endtask
  // ======
  // Scenarios
  task automatic t_power_on();
    @(posedge ref_clk_i);
    chk({31'h0, keep_regs_undef_o}, 32'h1);
    wait_core(1'b0);
    chk_rng(PW + SPAN, PW + SPAN + 40);
    rd_chk(FLAGS_ADDR, 32'h3);
    wr(FLAGS_ADDR, 32'h0);
    rd_chk(FLAGS_ADDR, 32'h3);
    rd_chk(CONFIG_ADDR, 32'h0);
    wr(32'h0000_0010, 32'hFFFF_FFFF);
    rd_chk(32'h0000_0010, 32'h0);
    wr(PCS_ADDR, 32'h3);
    rd_chk(PCS_ADDR, 32'h3);
  endtask
  task automatic t_pin_halt();
    halted_i <= 1'b1;
    drive(1, 10);
    halted_i <= 1'b0;
    settle();
    chk({29'h0, reset_cause_o}, CAUSE_PIN_HALT);
    rd_chk(FLAGS_ADDR, 32'h2);
  endtask
  task automatic t_watchdog();
    drive(2, 1);
    chk({30'h0, master_clear_pin_oe_o, master_clear_pin_o}, 32'h0);
    settle();
    chk({31'h0, keep_regs_undef_o}, 32'h0);
    chk({29'h0, reset_cause_o}, CAUSE_WATCHDOG);
    rd_chk(FLAGS_ADDR, 32'h1);
    rd_chk(PCS_ADDR, 32'h3);
  endtask
  task automatic t_pin_run();
    int k;
    k = n_rst;
    drive(1, 2);
    repeat (6) @(posedge ref_clk_i);
    chk(n_rst - k, 32'h0);
    drive(1, 300);
    wait_core(1'b0);
    chk_rng(0, 12);
    chk({29'h0, reset_cause_o}, CAUSE_PIN_RUN);
    rd_chk(FLAGS_ADDR, 32'h1);
  endtask
  task automatic t_wakes();
    int k;
    k = n_wake;
    halted_i <= 1'b1;
    drive(2, 1);
    halted_i <= 1'b0;
    settle();
    rd_chk(FLAGS_ADDR, 32'h0);
    halted_i <= 1'b1;
    drive(3, 1);
    halted_i <= 1'b0;
    settle();
    rd_chk(FLAGS_ADDR, 32'h2);
    chk(n_wake - k, 32'h2);
  endtask
  task automatic t_brownout();
    drive(0, 10);
    repeat (20) @(posedge ref_clk_i);
    chk({31'h0, core_reset_o}, 32'h1);
    drive(0, 10);
    wait_core(1'b0);
    chk_rng(PW + SPAN, PW + SPAN + 40);
    chk({29'h0, reset_cause_o}, CAUSE_BROWNOUT);
    rd_chk(FLAGS_ADDR, 32'h3);
    rd_chk(PCS_ADDR, 32'h2);
  endtask
  task automatic t_modes();
    logic [31:0] cfg [5] = '{32'h8, 32'h9, 32'hA, 32'hB, 32'h1};
    int          lo  [5] = '{SPAN, 0, PL + SPAN, PL, PW - 2};
    for (int i = 0; i < 5; i++) begin
      wr(CONFIG_ADDR, cfg[i]);
      drive(0, 10);
      wait_core(1'b0);
      chk_rng(lo[i], lo[i] + 24);
    end
    wr(CONFIG_ADDR, 32'h0);
  endtask
  task automatic t_por();
    logic [31:0] q;
    drive(4, 1);
    settle();
    chk({29'h0, reset_cause_o}, CAUSE_POWER_ON);
    rd_chk(FLAGS_ADDR, 32'h3);
    bus(1'b0, PCS_ADDR, 32'h0, q);
    chk(q & 32'h2, 32'h0);
    rd_chk(CONFIG_ADDR, 32'h0);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_power_on();
    t_pin_halt();
    t_watchdog();
    t_pin_run();
    t_wakes();
    t_brownout();
    t_modes();
    t_por();
    tally_and_finish();
  end
endmodule
